// ==== rtl/itcoa_top.sv ====
// Transfer control and own-address unit
//
// Contract
// RULE_01 - Stop request sends stop, cleared by hardware
// RULE_02 - Nack request cleared on stop, match, disable
// RULE_03 - Slave: nack request selects next byte answer
// RULE_04 - Master receive: last byte is nacked
// RULE_05 - Slave receive overrun always nacks; code answers a checked byte by the check result
// RULE_06 - Checked byte answer follows check result
// RULE_07 - Byte count sets transfer length
// RULE_08 - Count written only while start clear; code writes it on every control two write
// RULE_09 - Reload: flag, hold clock, await count
// RULE_10 - No reload: transfer ends after count
// RULE_11 - Software end: complete flag, hold clock
// RULE_12 - Automatic end: stop after last byte
// RULE_13 - End mode ignored in slave or reload
// RULE_14 - Check byte request set, hardware clears
// RULE_15 - Check request ignored in reload, plain slave
// RULE_16 - Without SMBus check request reads zero
// RULE_17 - Seven bits compare 7:1, ten compare all
// RULE_18 - Bit 10 picks address length
// RULE_19 - Bit 15 picks ack or nack of match
// RULE_20 - Slave byte control enables slave counting
// RULE_21 - Start cleared on sent, loss, timeout, disable
// RULE_22 - Internal counter loads and counts down
// RULE_23 - Reserved bits read zero
`timescale 1ns/10ps
module itcoa_top
    import itcoa_pkg::*;
#(
    parameter int   COUNT_W  = FIELD_W,
    parameter logic SMBUS_EN = 1'b1
) (
    input  wire logic                CLK,          // 50 MHz clock
    input  wire logic                RESET,        // Async reset, high
    input  wire logic                PSEL,         // APB select
    input  wire logic                PENABLE,      // APB enable
    input  wire logic                PWRITE,       // APB direction
    input  wire logic [ADDR_W-1:0]   PADDR,        // APB byte address
    input  wire logic [DATA_W-1:0]   PWDATA,       // APB write data
    output logic      [DATA_W-1:0]   PRDATA,       // APB read data
    output logic                     PREADY,       // APB ready
    output logic                     PSLVERR,      // APB error
    input  wire logic                SCL_IN,       // Bus clock pin
    input  wire logic                SDA_IN,       // Bus data pin
    input  wire logic                MASTER_MODE,  // Acting as master
    input  wire logic                RX_MODE,      // Receiving bytes
    input  wire logic                START_SENT,   // Start and address out
    input  wire logic                ARB_LOST,     // Arbitration lost
    input  wire logic                TIMEOUT,      // Bus timeout
    input  wire logic                STOP_SENT,    // Stop went out
    input  wire logic                BYTE_DONE,    // Byte moved
    input  wire logic                OVERRUN,      // Slave overrun
    input  wire logic                PEC_OK,       // Check byte matched
    input  wire logic                RX_ADDR_VALID,// Address received
    input  wire logic [OA_VAL_MSB:0] RX_ADDR,      // Received address
    input  wire logic                RX_ADDR_TEN,  // Ten-bit address
    output logic                     START_REQ,    // Start wanted
    output logic                     STOP_REQ,     // Stop wanted
    output logic                     NACK_SEND,    // Answer nack
    output logic                     SCL_HOLD,     // Stretch clock low
    output logic                     PEC_SEND,     // Next byte is check
    output logic                     ADDR_MATCH,   // Own address pulse
    output logic                     ADDR_ACK      // Ack the address
);
    generate
        if (COUNT_W < 1 || COUNT_W > FIELD_W) begin : g_chk
            $error("COUNT_W must be 1 to 8");
        end
    endgenerate

    // Registers
    logic                enable_ff;
    logic                sbc_ff;
    logic                pec_en_ff;
    logic [C2_LOW_MSB:0] low_ff;
    logic                start_ff;
    logic                stop_ff;
    logic                nack_ff;
    logic [COUNT_W-1:0]  count_ff;
    logic                reload_ff;
    logic                endm_ff;
    logic                pecreq_ff;
    logic [OA_VAL_MSB:0] oa_val_ff;
    logic                oa_len_ff;
    logic                oa_en_ff;
    logic [COUNT_W-1:0]  cnt_ff;
    logic                tc_ff;
    logic                tcr_ff;
    logic                bus_stop_ff;
    logic                match_ff;
    logic                ack_ff;
    logic [DATA_W-1:0]   prdata_ff;
    logic                sda_prev_ff;

    // Bus decode
    logic apb_setup;
    logic apb_wr;
    logic sel_c1;
    logic sel_c2;
    logic sel_oa;
    logic sel_st;
    logic mapped;
    assign sel_c1    = (PADDR == OFS_CTRL_ONE);
    assign sel_c2    = (PADDR == OFS_CTRL_TWO);
    assign sel_oa    = (PADDR == OFS_OWN_ADDR);
    assign sel_st    = (PADDR == OFS_STATUS);
    assign mapped    = sel_c1 || sel_c2 || sel_oa || sel_st;
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr    = PSEL && PENABLE && PWRITE && mapped;
    assign PREADY    = 1'b1;
    assign PSLVERR   = PSEL && PENABLE && !mapped;
    assign PRDATA    = prdata_ff;

    logic wr_c1;
    logic wr_c2;
    logic wr_oa;
    assign wr_c1 = apb_wr && sel_c1;
    assign wr_c2 = apb_wr && sel_c2;
    assign wr_oa = apb_wr && sel_oa;

    logic set_start;
    logic set_stop;
    logic set_nack;
    logic set_pec;
    assign set_start = wr_c2 && PWDATA[C2_START];
    assign set_stop  = wr_c2 && PWDATA[C2_STOP];
    assign set_nack  = wr_c2 && PWDATA[C2_NACK];
    assign set_pec   = wr_c2 && PWDATA[C2_PECREQ] && SMBUS_EN; // RULE_16

    logic [COUNT_W-1:0] wr_count;
    assign wr_count = PWDATA[C2_CNT_LSB +: COUNT_W];

    // Bus pins and received stop
    logic [1:0] pins;
    logic       scl_lvl;
    logic       sda_lvl;
    logic       stop_rx;
    itcoa_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk    (CLK),
        .reset  (RESET),
        .pin_in ({SCL_IN, SDA_IN}),
        .level  (pins)
    );
    assign scl_lvl = pins[1];
    assign sda_lvl = pins[0];
    // Data rising while clock high marks a stop
    assign stop_rx = scl_lvl && sda_lvl && !sda_prev_ff;

    // Own address
    logic addr_hit;
    logic addr_event;
    itcoa_addr_match u_match (
        .own_addr (oa_val_ff),
        .ten_bit  (oa_len_ff),
        .rx_addr  (RX_ADDR),
        .rx_ten   (RX_ADDR_TEN),
        .hit      (addr_hit)
    );
    assign addr_event = RX_ADDR_VALID && addr_hit && oa_en_ff; // RULE_19

    // Counting state
    logic cnt_active;
    logic last_byte;
    logic done_last;
    logic pec_live;
    logic pec_byte;
    logic auto_stop;
    logic set_tc;
    logic set_tcr;
    logic reload_wr;
    assign cnt_active = enable_ff && (MASTER_MODE || sbc_ff);   // RULE_07 RULE_20
    assign last_byte  = cnt_active && (cnt_ff == CNT_ONE[COUNT_W-1:0]);
    assign done_last  = BYTE_DONE && last_byte;                 // RULE_10
    assign pec_live   = pecreq_ff && !reload_ff && cnt_active;  // RULE_15
    assign pec_byte   = pec_live && last_byte;
    assign auto_stop  = done_last && MASTER_MODE && !reload_ff && endm_ff; // RULE_12 RULE_13
    assign set_tc     = done_last && MASTER_MODE && !reload_ff && !endm_ff; // RULE_11 RULE_13
    assign set_tcr    = done_last && reload_ff;                 // RULE_09
    assign reload_wr  = wr_c2 && tcr_ff && (wr_count != '0);

    // Acknowledge choice
    logic nack_pec;
    logic nack_ovr;
    logic nack_last;
    logic nack_sw;
    assign nack_pec  = pec_byte && pec_en_ff && !PEC_OK;            // RULE_06
    assign nack_ovr  = !MASTER_MODE && RX_MODE && OVERRUN;          // RULE_05
    assign nack_last = MASTER_MODE && RX_MODE && last_byte
                       && !reload_ff;                               // RULE_04
    assign nack_sw   = !MASTER_MODE && nack_ff;                     // RULE_03
    assign NACK_SEND = (pec_byte && pec_en_ff) ? nack_pec
                     : (nack_ovr || nack_last || nack_sw);

    // Next values of request bits
    logic nxt_start;
    logic nxt_stop;
    logic nxt_nack;
    logic nxt_pec;
    assign nxt_start = !enable_ff ? 1'b0
                     : set_start ? 1'b1
                     : (START_SENT || ARB_LOST || TIMEOUT) ? 1'b0
                     : start_ff;                                    // RULE_21
    assign nxt_stop  = !enable_ff ? 1'b0
                     : (set_stop || auto_stop) ? 1'b1
                     : STOP_SENT ? 1'b0
                     : stop_ff;                                     // RULE_01
    assign nxt_nack  = !enable_ff ? 1'b0
                     : set_nack ? 1'b1
                     : (STOP_SENT || addr_event) ? 1'b0
                     : nack_ff;                                     // RULE_02
    assign nxt_pec   = !enable_ff ? 1'b0
                     : set_pec ? 1'b1
                     : ((BYTE_DONE && pec_byte) || stop_rx
                        || addr_event) ? 1'b0
                     : pecreq_ff;                                   // RULE_14

    // Counter loads on start or reload
    logic [COUNT_W-1:0] nxt_cnt;
    assign nxt_cnt = !enable_ff ? '0
                   : (START_SENT || reload_wr) ? count_ff
                   : (BYTE_DONE && cnt_active && cnt_ff != '0)
                     ? cnt_ff - 1'b1
                   : cnt_ff;                                        // RULE_22

    // Hardware set wins over software clear
    logic nxt_tc;
    logic nxt_tcr;
    assign nxt_tc  = !enable_ff ? 1'b0
                   : set_tc ? 1'b1
                   : (set_start || set_stop) ? 1'b0
                   : tc_ff;                                         // RULE_11
    assign nxt_tcr = !enable_ff ? 1'b0
                   : set_tcr ? 1'b1
                   : reload_wr ? 1'b0
                   : tcr_ff;                                        // RULE_09

    // Read mux
    logic [DATA_W-1:0] rd_c1;
    logic [DATA_W-1:0] rd_c2;
    logic [DATA_W-1:0] rd_oa;
    logic [DATA_W-1:0] rd_st;
    logic [DATA_W-1:0] rd_word;
    always_comb begin
        rd_c1 = RST_WORD;
        rd_c2 = RST_WORD;
        rd_oa = RST_WORD;
        rd_st = RST_WORD;
        rd_c1[C1_ENABLE]               = enable_ff;
        rd_c1[C1_SBC]                  = sbc_ff;
        rd_c1[C1_PEC_EN]               = pec_en_ff;
        rd_c2[C2_LOW_MSB:0]            = low_ff;
        rd_c2[C2_START]                = start_ff;
        rd_c2[C2_STOP]                 = stop_ff;
        rd_c2[C2_NACK]                 = nack_ff;
        rd_c2[C2_CNT_LSB +: COUNT_W]   = count_ff;
        rd_c2[C2_RELOAD]               = reload_ff;
        rd_c2[C2_ENDM]                 = endm_ff;
        rd_c2[C2_PECREQ]               = pecreq_ff && SMBUS_EN; // RULE_16
        rd_oa[OA_VAL_MSB:0]            = oa_val_ff;
        rd_oa[OA_LEN]                  = oa_len_ff;
        rd_oa[OA_EN]                   = oa_en_ff;
        rd_st[ST_TC]                   = tc_ff;
        rd_st[ST_TCR]                  = tcr_ff;
        rd_st[ST_BUS_STOP]             = bus_stop_ff;
        rd_st[ST_CNT_LSB +: COUNT_W]   = cnt_ff;
    end
    // Unlisted and reserved bits stay zero
    assign rd_word = sel_c1 ? rd_c1
                   : sel_c2 ? rd_c2
                   : sel_oa ? rd_oa
                   : sel_st ? rd_st
                   : RST_WORD;                                      // RULE_23

    // Control one and own address storage
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            enable_ff <= 1'b0;
            sbc_ff    <= 1'b0;
            pec_en_ff <= 1'b0;
            oa_val_ff <= '0;
            oa_len_ff <= 1'b0;
            oa_en_ff  <= 1'b0;
        end else if (wr_c1) begin
            enable_ff <= PWDATA[C1_ENABLE];
            sbc_ff    <= PWDATA[C1_SBC];
            pec_en_ff <= PWDATA[C1_PEC_EN] && SMBUS_EN;
        end else if (wr_oa) begin
            oa_val_ff <= PWDATA[OA_VAL_MSB:0];                      // RULE_17
            oa_len_ff <= PWDATA[OA_LEN];                            // RULE_18
            oa_en_ff  <= PWDATA[OA_EN];                             // RULE_19
        end
    end

    // Control two plain fields
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            low_ff    <= '0;
            count_ff  <= '0;
            reload_ff <= 1'b0;
            endm_ff   <= 1'b0;
        end else if (wr_c2) begin
            low_ff    <= PWDATA[C2_LOW_MSB:0];
            count_ff  <= wr_count;                                  // RULE_08
            reload_ff <= PWDATA[C2_RELOAD];
            endm_ff   <= PWDATA[C2_ENDM];
        end
    end

    // Request bits, counter and flags
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            start_ff  <= 1'b0;
            stop_ff   <= 1'b0;
            nack_ff   <= 1'b0;
            pecreq_ff <= 1'b0;
            cnt_ff    <= '0;
            tc_ff     <= 1'b0;
            tcr_ff    <= 1'b0;
        end else begin
            start_ff  <= nxt_start;
            stop_ff   <= nxt_stop;
            nack_ff   <= nxt_nack;
            pecreq_ff <= nxt_pec;
            cnt_ff    <= nxt_cnt;
            tc_ff     <= nxt_tc;
            tcr_ff    <= nxt_tcr;
        end
    end

    // Address answer, stop seen, read data
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            match_ff    <= 1'b0;
            ack_ff      <= 1'b0;
            bus_stop_ff <= 1'b0;
            sda_prev_ff <= 1'b1;
            prdata_ff   <= RST_WORD;
        end else begin
            match_ff    <= addr_event;
            if (RX_ADDR_VALID) begin
                ack_ff  <= addr_event;                              // RULE_19
            end
            sda_prev_ff <= sda_lvl;
            bus_stop_ff <= enable_ff && (stop_rx
                           || (bus_stop_ff && !set_start));
            if (apb_setup) begin
                prdata_ff <= rd_word;
            end
        end
    end

    // Outputs
    assign START_REQ  = start_ff;
    assign STOP_REQ   = stop_ff && MASTER_MODE;                     // RULE_01
    assign SCL_HOLD   = tc_ff || tcr_ff;                            // RULE_09 RULE_11
    assign PEC_SEND   = pec_byte;                                   // RULE_15
    assign ADDR_MATCH = match_ff;
    assign ADDR_ACK   = ack_ff;
endmodule // itcoa_top

// ==== pkg/itcoa_pkg.sv ====
// Constants of the transfer control block
package itcoa_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          FIELD_W       = 8;
    localparam logic [7:0]  OFS_CTRL_ONE  = 8'h00;
    localparam logic [7:0]  OFS_CTRL_TWO  = 8'h04;
    localparam logic [7:0]  OFS_OWN_ADDR  = 8'h08;
    localparam logic [7:0]  OFS_STATUS    = 8'h18;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    // Control one
    localparam int          C1_ENABLE     = 0;
    localparam int          C1_SBC        = 16;
    localparam int          C1_PEC_EN     = 23;
    // Control two
    localparam int          C2_LOW_MSB    = 12;
    localparam int          C2_START      = 13;
    localparam int          C2_STOP       = 14;
    localparam int          C2_NACK       = 15;
    localparam int          C2_CNT_LSB    = 16;
    localparam int          C2_CNT_MSB    = 23;
    localparam int          C2_RELOAD     = 24;
    localparam int          C2_ENDM       = 25;
    localparam int          C2_PECREQ     = 26;
    // Own address one
    localparam int          OA_VAL_MSB    = 9;
    localparam int          OA_LEN        = 10;
    localparam int          OA_EN         = 15;
    localparam int          OA7_MSB       = 7;
    localparam int          OA7_LSB       = 1;
    // Status
    localparam int          ST_TC         = 0;
    localparam int          ST_TCR        = 1;
    localparam int          ST_BUS_STOP   = 2;
    localparam int          ST_CNT_LSB    = 8;
    localparam int          ST_CNT_MSB    = 15;
    localparam logic [7:0]  CNT_ZERO      = 8'h00;
    localparam logic [7:0]  CNT_ONE       = 8'h01;
endpackage

// ==== rtl/itcoa_sync.sv ====
// Three-stage pin synchroniser
`timescale 1ns/10ps
module itcoa_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,    // Block clock
    input  wire logic             reset,  // Async reset, high
    input  wire logic [WIDTH-1:0] pin_in, // Raw pins
    output logic      [WIDTH-1:0] level   // Filtered level
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] lvl_ff;
    logic [WIDTH-1:0] nxt_lvl;

    // Idle bus is high, so reset to ones
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_ff  <= '1;
            s2_ff  <= '1;
            s3_ff  <= '1;
            lvl_ff <= '1;
        end else begin
            s1_ff  <= pin_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    // A change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
        end
    endgenerate

    assign level = lvl_ff;
endmodule // itcoa_sync

// ==== rtl/itcoa_addr_match.sv ====
// Own-address comparator for 7-bit and 10-bit addressing
`timescale 1ns/10ps
module itcoa_addr_match
    import itcoa_pkg::*;
(
    input  wire logic [OA_VAL_MSB:0] own_addr, // Stored address
    input  wire logic                ten_bit,  // Length select
    input  wire logic [OA_VAL_MSB:0] rx_addr,  // Received address
    input  wire logic                rx_ten,   // Received as 10-bit
    output logic                     hit       // Address equal
);
    function automatic logic seven_eq(input logic [OA_VAL_MSB:0] a,
                                      input logic [OA_VAL_MSB:0] b);
        seven_eq = (a[OA7_MSB:OA7_LSB] == b[OA7_MSB:OA7_LSB]);
    endfunction

    // Seven-bit compares bits 7:1
    logic hit7;
    logic hit10;
    assign hit7  = !ten_bit && !rx_ten && seven_eq(own_addr, rx_addr); // RULE_17 RULE_18
    assign hit10 = ten_bit && rx_ten && (own_addr == rx_addr);         // RULE_17 RULE_18
    assign hit   = hit7 || hit10;
endmodule // itcoa_addr_match

// ==== verif/itcoa_top_properties.sv ====
// Port-level assertions
`timescale 1ns/10ps
module itcoa_chk
    import itcoa_pkg::*;
#(
    parameter logic SMBUS_EN = 1'b1
) (
    input logic              CLK,           // Clock
    input logic              RESET,         // Reset
    input logic              PSEL,          // Select
    input logic              PENABLE,       // Enable
    input logic              PWRITE,        // Direction
    input logic [ADDR_W-1:0] PADDR,         // Address
    input logic [DATA_W-1:0] PWDATA,        // Write data
    input logic              MASTER_MODE,   // Master
    input logic              RX_MODE,       // Receiving
    input logic              START_SENT,    // Start out
    input logic              ARB_LOST,      // Lost
    input logic              TIMEOUT,       // Timeout
    input logic              STOP_SENT,     // Stop out
    input logic              BYTE_DONE,     // Byte moved
    input logic              OVERRUN,       // Overrun
    input logic              PEC_OK,        // Check good
    input logic              RX_ADDR_VALID, // Address in
    input logic              START_REQ,     // Start wanted
    input logic              STOP_REQ,      // Stop wanted
    input logic              NACK_SEND,     // Nack answer
    input logic              SCL_HOLD,      // Clock held
    input logic              PEC_SEND,      // Check byte
    input logic              ADDR_MATCH,    // Match pulse
    input logic              ADDR_ACK       // Address ack
);
    logic en_ff;
    logic pec_ff;
    wire  wr = PSEL && PENABLE && PWRITE;

    // Mirror of the enable bits
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            en_ff  <= 1'b0;
            pec_ff <= 1'b0;
        end else if (wr && PADDR == OFS_CTRL_ONE) begin
            en_ff  <= PWDATA[C1_ENABLE];
            pec_ff <= PWDATA[C1_PEC_EN] & SMBUS_EN;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence start_end_s;
        (START_SENT || ARB_LOST || TIMEOUT) && !wr;
    endsequence

    start_clear_a: assert property (start_end_s |=> !START_REQ)
        else $error("start not cleared");
    stop_clear_a: assert property (STOP_SENT && !wr |=> !STOP_REQ)
        else $error("stop not cleared");
    stop_master_a: assert property (STOP_REQ |-> MASTER_MODE)
        else $error("stop outside master");
    stop_cause_a: assert property ($rose(STOP_REQ) |->
        $past(wr) || $past(BYTE_DONE) || !$past(MASTER_MODE))
        else $error("stop without cause");
    hold_cause_a: assert property ($rose(SCL_HOLD) |-> $past(BYTE_DONE))
        else $error("hold without byte");
    addr_ack_a: assert property (RX_ADDR_VALID && en_ff |=>
        ADDR_ACK == ADDR_MATCH)
        else $error("ack differs from match");
    overrun_nack_a: assert property (en_ff && OVERRUN && RX_MODE &&
        !MASTER_MODE && !PEC_SEND |-> NACK_SEND)
        else $error("overrun not nacked");
    pec_answer_a: assert property (en_ff && pec_ff && PEC_SEND |->
        NACK_SEND == !PEC_OK)
        else $error("check answer wrong");
endmodule // itcoa_chk

bind itcoa_top itcoa_chk #(.SMBUS_EN(SMBUS_EN)) i_chk (.*);

// ==== verif/itcoa_far_bus.sv ====
// Far-side bus model
`timescale 1ns/10ps
module itcoa_far_bus (
    input  wire logic  clk,        // Block clock
    output logic       scl,        // Bus clock, pulled up
    output logic       sda,        // Bus data, pulled up
    output logic       addr_valid, // Address seen pulse
    output logic [9:0] addr,       // Address seen
    output logic       addr_ten    // Ten-bit form
);
    initial begin
        scl        = 1'b1;
        sda        = 1'b1;
        addr_valid = 1'b0;
        addr       = 10'h000;
        addr_ten   = 1'b0;
    end

    // Start, one 160 ns clock period, stop
    task automatic send_stop;
        @(posedge clk) sda <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic send_addr(input logic [9:0] a, input logic t);
        @(posedge clk);
        addr       <= a;
        addr_ten   <= t;
        addr_valid <= 1'b1;
        @(posedge clk);
        addr_valid <= 1'b0;
        addr       <= ~a;
        #1;
    endtask
endmodule // itcoa_far_bus

// ==== verif/test_i2c_transfer_ctrl_own_addr.sv ====
// Bench for the transfer control block
`timescale 1ns/10ps
module test_i2c_transfer_ctrl_own_addr;
    import itcoa_pkg::*;
    localparam logic [31:0] ST = 32'h1 << C2_START,
        SP = 32'h1 << C2_STOP,
        NK = 32'h1 << C2_NACK,
        C1 = 32'h1 << C2_CNT_LSB,
        C2 = 32'h2 << C2_CNT_LSB,
        RL = 32'h1 << C2_RELOAD,
        EM = 32'h1 << C2_ENDM,
        PQ = 32'h1 << C2_PECREQ;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        scl, sda, master, rx, ovr, pec_ok, av, aten;
    logic [4:0]  ev;
    logic [9:0]  ra;
    logic        start_req, stop_req, nack, hold, pec_send, match, ack;
    logic [31:0] oa_tab [8] = '{32'h8054, 32'h8054, 32'h8054, 32'h86a5,
                                32'h86a5, 32'h86a5, 32'h0054, 32'h0054};
    logic [9:0]  rx_tab [8] = '{10'h054, 10'h055, 10'h056, 10'h2a5,
                                10'h2a4, 10'h1a5, 10'h054, 10'h055};
    logic [7:0]  ten_tab = 8'b0011_1000, ack_tab = 8'b0000_1011;
    int          err_count, cmp_count, cyc;

    itcoa_top i_dut (.CLK(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCL_IN(scl),
        .SDA_IN(sda), .MASTER_MODE(master), .RX_MODE(rx),
        .START_SENT(ev[0]), .ARB_LOST(ev[1]), .TIMEOUT(ev[2]),
        .STOP_SENT(ev[3]), .BYTE_DONE(ev[4]), .OVERRUN(ovr),
        .PEC_OK(pec_ok), .RX_ADDR_VALID(av), .RX_ADDR(ra),
        .RX_ADDR_TEN(aten), .START_REQ(start_req), .STOP_REQ(stop_req),
        .NACK_SEND(nack), .SCL_HOLD(hold), .PEC_SEND(pec_send),
        .ADDR_MATCH(match), .ADDR_ACK(ack));
    itcoa_far_bus i_far (.clk(clk), .scl(scl), .sda(sda),
        .addr_valid(av), .addr(ra), .addr_ten(aten));

    always #10 clk = ~clk;

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        #1;
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {master, rx, ovr, pec_ok, ev} = 9'h180;
        err_count = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(OFS_OWN_ADDR);
        chk(q, RST_WORD);
        wr(OFS_OWN_ADDR, 32'hffff_ffff);
        rd(OFS_OWN_ADDR);
        chk(q, 32'h0000_87ff);
        rd(8'h40);
        chk({q[30:0], e}, 32'h1);
        $display("test registers done");
        wr(OFS_CTRL_ONE, 32'h0080_0001);
        for (int i = 1; i < 3; i++) begin
            wr(OFS_CTRL_TWO, ST);
            chk(start_req, 1'b1);
            pulse(i);
            chk(start_req, 1'b0);
        end
        wr(OFS_CTRL_TWO, C2 | ST | EM);
        pulse(0);
        chk(start_req, 1'b0);
        rd(OFS_STATUS);
        chk(q[ST_CNT_MSB:ST_CNT_LSB], 32'h2);
        pulse(4);
        chk(nack, 1'b1);
        pulse(4);
        chk(stop_req, 1'b1);
        pulse(3);
        chk(stop_req, 1'b0);
        wr(OFS_CTRL_TWO, C1 | ST);
        pulse(0);
        pulse(4);
        rd(OFS_STATUS);
        chk(q[2:0], 32'h1);
        chk(hold, 1'b1);
        wr(OFS_CTRL_TWO, SP);
        chk({hold, stop_req}, 32'h1);
        pulse(3);
        $display("test master end modes done");
        wr(OFS_CTRL_TWO, C1 | ST | RL | EM);
        pulse(0);
        pulse(4);
        rd(OFS_STATUS);
        chk({q[1], hold, stop_req}, 32'h6);
        wr(OFS_CTRL_TWO, C1 | EM);
        chk(hold, 1'b0);
        pulse(4);
        chk(stop_req, 1'b1);
        pulse(3);
        wr(OFS_CTRL_TWO, C2 | ST | PQ);
        pulse(0);
        pulse(4);
        chk(pec_send, 1'b1);
        @(posedge clk) pec_ok <= 1'b1;
        #1 chk(nack, 1'b0);
        i_far.send_stop();
        rd(OFS_CTRL_TWO);
        chk(q[C2_PECREQ], 1'b0);
        $display("test reload and check byte done");
        master <= 1'b0;
        wr(OFS_CTRL_TWO, NK);
        chk(nack, 1'b1);
        wr(OFS_CTRL_TWO, 32'h0);
        chk(nack, 1'b1);
        wr(OFS_OWN_ADDR, 32'h8054);
        i_far.send_addr(10'h054, 1'b0);
        chk({ack, nack}, 32'h2);
        @(posedge clk) ovr <= 1'b1;
        #1 chk(nack, 1'b1);
        ovr <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_OWN_ADDR, oa_tab[i]);
            i_far.send_addr(rx_tab[i], ten_tab[i]);
            chk({match, ack}, {2{ack_tab[i]}});
        end
        $display("test slave and own address done");
        give_verdict();
    end
endmodule // test_i2c_transfer_ctrl_own_addr
